// *** design/mke_defs.vh ***
// Constants for the per-frame key stream encryption block.
// Assumes inclusion by bare name from the design file.
`ifndef MKE_DEFS_VH
`define MKE_DEFS_VH

// Register byte offsets
`define MKE_OFS_CTRL 8'h00
`define MKE_OFS_TAILCODE 8'h04
`define MKE_OFS_BEARER 8'h08
`define MKE_OFS_PAYLOAD 8'h0C
`define MKE_OFS_START_FN 8'h10
`define MKE_OFS_STOP_FN 8'h14
`define MKE_OFS_STATUS 8'h18
`define MKE_OFS_KEY0 8'h20
`define MKE_OFS_KEY1 8'h24
`define MKE_OFS_KEY2 8'h28
`define MKE_OFS_KEY3 8'h2C

// Control field positions
`define MKE_CTRL_ARM 0
`define MKE_CTRL_FIXED 1
`define MKE_CTRL_ADVANCED 2
`define MKE_CTRL_DSIMPLEX 3
`define MKE_CTRL_FMT_LSB 4
`define MKE_CTRL_KEY128 6

// Reset values
`define MKE_CTRL_RST 32'h0000_0000
`define MKE_TAILCODE_RST 3'h6
`define MKE_PAYLOAD_RST 9'h140

// B-field formats
`define MKE_FMT_UNPROT 2'h0
`define MKE_FMT_SINGLE 2'h1
`define MKE_FMT_MULTI 2'h2
`define MKE_FMT_CODED 2'h3

// Field layout of the full slot, two-level structure
`define MKE_SEG_BITS 360
`define MKE_KS_BITS 720
`define MKE_FIELD_BITS 388
`define MKE_TAIL_FIRST 8
`define MKE_TAIL_LAST 47
`define MKE_B_FIRST 64
`define MKE_B_LAST 383
`define MKE_TAIL_KSS 40
`define MKE_SUB_PERIOD 80
`define MKE_SUB_DATA 64
`define MKE_SINGLE_DATA 304
`define MKE_TAIL_TYPE_LSB 1
`define MKE_LBN_TOP 4'hF

`endif

// *** design/mke_keystream_cipher.v ***
// Per-frame key stream XOR datapath with init vector build and APB registers.
// Assumes a generator on the same clock that emits 720 key bits in output
// order after each load pulse, and field bits arriving serially, a0 first.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mke_defs.vh"

module mke_keystream_cipher (
    input wire i_sys_clk,
    input wire i_rst_b,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_frame_strobe,
    input wire [3:0] i_frame_num,
    input wire [23:0] i_multiframe,
    output reg o_ksg_load,
    output reg [34:0] o_init_vector,
    output wire [127:0] o_cipher_key,
    input wire i_ks_valid,
    input wire i_ks_bit,
    output wire o_ks_ready,
    input wire i_fld_valid,
    input wire i_fld_first,
    input wire i_fld_rx,
    input wire i_fld_second,
    input wire i_fld_bit,
    output wire o_fld_ready,
    output reg o_fld_valid,
    output reg o_fld_bit,
    output reg o_enc_active
);

    // Field layout constants held at the widths of the position arithmetic
    localparam [8:0] LP_TAIL_FIRST = `MKE_TAIL_FIRST;
    localparam [8:0] LP_TAIL_LAST = `MKE_TAIL_LAST;
    localparam [8:0] LP_B_FIRST = `MKE_B_FIRST;
    localparam [8:0] LP_B_LAST = `MKE_B_LAST;
    localparam [8:0] LP_SUB_PERIOD = `MKE_SUB_PERIOD;
    localparam [8:0] LP_SUB_DATA = `MKE_SUB_DATA;
    localparam [8:0] LP_SINGLE_DATA = `MKE_SINGLE_DATA;
    localparam [9:0] LP_TAIL_KSS = `MKE_TAIL_KSS;
    localparam [9:0] LP_SEG_BITS = `MKE_SEG_BITS;
    localparam [9:0] LP_KS_BITS = `MKE_KS_BITS;

    reg [31:0] ctrl;
    reg [2:0] tail_code;
    reg [3:0] bearer_num;
    reg [8:0] payload_bits;
    reg [27:0] start_fn;
    reg [27:0] stop_fn;
    reg [31:0] key_word [0:3];
    reg [`MKE_KS_BITS-1:0] ks_buf;
    reg [9:0] ks_cnt;
    reg ks_collect;
    reg [8:0] fld_pos;
    reg [7:0] hdr;
    reg load_pend;
    reg [27:0] fn_now;
    reg [31:0] rdata;
    reg addr_ok;

    wire arm;
    wire fixed_end;
    wire advanced;
    wire dsimplex;
    wire key128;
    wire [1:0] bfmt;
    wire ks_done;
    wire wr_en;
    wire [8:0] cur_pos;
    wire use_p;
    wire tail_ct;
    wire [9:0] seg_idx;
    wire hit;
    wire [27:0] fn_in;

    assign arm = ctrl[`MKE_CTRL_ARM];
    assign fixed_end = ctrl[`MKE_CTRL_FIXED];
    assign advanced = ctrl[`MKE_CTRL_ADVANCED];
    assign dsimplex = ctrl[`MKE_CTRL_DSIMPLEX];
    assign key128 = ctrl[`MKE_CTRL_KEY128];
    assign bfmt = ctrl[`MKE_CTRL_FMT_LSB+1:`MKE_CTRL_FMT_LSB];
    assign fn_in = {i_multiframe, i_frame_num};

    // Whether a field position is encrypted under the selected format
    function map_use;
        input [8:0] pos;
        input [1:0] fmt;
        input ct;
        input [8:0] npay;
        reg [8:0] b;
        begin
            b = pos - LP_B_FIRST;
            map_use = 1'b0;
            if (pos >= LP_TAIL_FIRST && pos <= LP_TAIL_LAST) begin
                map_use = ct;
            end else if (pos >= LP_B_FIRST && pos <= LP_B_LAST) begin
                case (fmt)
                    `MKE_FMT_UNPROT: begin
                        map_use = 1'b1;
                    end
                    `MKE_FMT_SINGLE: begin
                        map_use = (b < LP_SINGLE_DATA);
                    end
                    `MKE_FMT_MULTI: begin
                        map_use = (b < LP_SINGLE_DATA) &&
                                  ((b % LP_SUB_PERIOD) < LP_SUB_DATA);
                    end
                    default: begin
                        map_use = (b < npay);
                    end
                endcase
            end
        end
    endfunction

    // Segment bit index that meets a field position
    function [9:0] map_idx;
        input [8:0] pos;
        begin
            if (pos <= LP_TAIL_LAST) begin
                map_idx = {1'b0, pos - LP_TAIL_FIRST};
            end else begin
                map_idx = {1'b0, pos - LP_B_FIRST} + LP_TAIL_KSS;
            end
        end
    endfunction

    // APB: zero-wait slave, unmapped offsets answer with an error
    assign o_pready = 1'b1;
    assign wr_en = i_psel & i_penable & i_pwrite;
    assign o_pslverr = i_psel & i_penable & ~addr_ok;
    assign o_prdata = (i_psel & i_penable & ~i_pwrite) ? rdata : 32'h0000_0000;

    always @* begin
        addr_ok = 1'b1;
        rdata = 32'h0000_0000;
        case (i_paddr)
            `MKE_OFS_CTRL: rdata = ctrl;
            `MKE_OFS_TAILCODE: rdata = {29'h0000_0000, tail_code};
            `MKE_OFS_BEARER: rdata = {28'h000_0000, bearer_num};
            `MKE_OFS_PAYLOAD: rdata = {23'h00_0000, payload_bits};
            `MKE_OFS_START_FN: rdata = {4'h0, start_fn};
            `MKE_OFS_STOP_FN: rdata = {4'h0, stop_fn};
            `MKE_OFS_STATUS: rdata = {20'h0_0000, ks_cnt, ks_done, o_enc_active};
            `MKE_OFS_KEY0: rdata = key_word[0];
            `MKE_OFS_KEY1: rdata = key_word[1];
            `MKE_OFS_KEY2: rdata = key_word[2];
            `MKE_OFS_KEY3: rdata = key_word[3];
            default: addr_ok = 1'b0;
        endcase
    end

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl <= `MKE_CTRL_RST;
            tail_code <= `MKE_TAILCODE_RST;
            bearer_num <= 4'h0;
            payload_bits <= `MKE_PAYLOAD_RST;
            start_fn <= 28'h000_0000;
            stop_fn <= 28'h000_0000;
            key_word[0] <= 32'h0000_0000;
            key_word[1] <= 32'h0000_0000;
            key_word[2] <= 32'h0000_0000;
            key_word[3] <= 32'h0000_0000;
        end else if (wr_en) begin
            case (i_paddr)
                `MKE_OFS_CTRL: ctrl <= {25'h000_0000, i_pwdata[6:0]};
                `MKE_OFS_TAILCODE: tail_code <= i_pwdata[2:0];
                `MKE_OFS_BEARER: bearer_num <= i_pwdata[3:0];
                `MKE_OFS_PAYLOAD: payload_bits <= i_pwdata[8:0];
                `MKE_OFS_START_FN: start_fn <= i_pwdata[27:0];
                `MKE_OFS_STOP_FN: stop_fn <= i_pwdata[27:0];
                `MKE_OFS_KEY0: key_word[0] <= i_pwdata;
                `MKE_OFS_KEY1: key_word[1] <= i_pwdata;
                `MKE_OFS_KEY2: key_word[2] <= i_pwdata;
                `MKE_OFS_KEY3: key_word[3] <= i_pwdata;
                default: ctrl <= ctrl;
            endcase
        end
    end

    // key width; a 64-bit key leaves the upper half at zero
    assign o_cipher_key = {key128 ? {key_word[3], key_word[2]} : 64'h0000_0000_0000_0000,
                           key_word[1], key_word[0]};

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_enc_active <= 1'b0;
            fn_now <= 28'h000_0000;
            load_pend <= 1'b0;
        end else begin
            load_pend <= 1'b0;
            if (i_frame_strobe) begin
                fn_now <= fn_in;
                if (!arm) begin
                    o_enc_active <= 1'b0;
                end else if (fn_in == start_fn) begin
                    o_enc_active <= 1'b1;
                    load_pend <= 1'b1;
                end else if (fn_in == stop_fn) begin
                    o_enc_active <= 1'b0;
                end else begin
                    load_pend <= o_enc_active;
                end
            end
        end
    end

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ksg_load <= 1'b0;
            o_init_vector <= 35'h0_0000_0000;
        end else begin
            o_ksg_load <= load_pend;
            if (load_pend) begin
                o_init_vector <= {3'h0, advanced ? (`MKE_LBN_TOP - bearer_num) : 4'h0, fn_now};
            end
        end
    end

    // collect 720 consecutive key bits in output order
    assign ks_done = (ks_cnt == LP_KS_BITS);
    assign o_ks_ready = ks_collect & ~ks_done;

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ks_cnt <= 10'h000;
            ks_collect <= 1'b0;
            ks_buf <= {`MKE_KS_BITS{1'b0}};
        end else if (o_ksg_load) begin
            ks_cnt <= 10'h000;
            ks_collect <= 1'b1;
        end else if (i_ks_valid && o_ks_ready) begin
            ks_buf[ks_cnt] <= i_ks_bit;
            ks_cnt <= ks_cnt + 10'h001;
        end
    end

    // Fields stall while an encrypted frame still waits for its key bits
    // A pending reload would otherwise let the last frame's key stream through
    assign o_fld_ready = ~o_enc_active | (ks_done & ~load_pend & ~o_ksg_load);
    assign cur_pos = i_fld_first ? 9'h000 : fld_pos;

    // tail type from the clear header
    assign tail_ct = (hdr[`MKE_TAIL_TYPE_LSB+2:`MKE_TAIL_TYPE_LSB] == tail_code);

    // segment choice by end and direction, or by the second-field flag in dsimplex mode
    assign use_p = dsimplex ? i_fld_second : (fixed_end ? i_fld_rx : ~i_fld_rx);
    // second segment starts m bits later
    assign seg_idx = map_idx(cur_pos) + (use_p ? LP_SEG_BITS : 10'h000);
    assign hit = o_enc_active & map_use(cur_pos, bfmt, tail_ct, payload_bits);

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fld_pos <= 9'h000;
            hdr <= 8'h00;
            o_fld_valid <= 1'b0;
            o_fld_bit <= 1'b0;
        end else begin
            o_fld_valid <= i_fld_valid & o_fld_ready;
            if (i_fld_valid && o_fld_ready) begin
                fld_pos <= cur_pos + 9'h001;
                if (cur_pos < LP_TAIL_FIRST) begin
                    hdr[cur_pos[2:0]] <= i_fld_bit;
                end
                // same XOR both ways, ahead of checks
                o_fld_bit <= i_fld_bit ^ (hit & ks_buf[seg_idx]);
            end
        end
    end

endmodule // mke_keystream_cipher
`default_nettype wire

// *** tb/mke_checker.sv ***
// Checker: port-level timing and pass-through properties of the cipher block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mke_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_frame_strobe,
    input wire logic [3:0] i_frame_num,
    input wire logic [23:0] i_multiframe,
    input wire logic i_fld_valid,
    input wire logic i_fld_bit,
    input wire logic o_pslverr,
    input wire logic o_ksg_load,
    input wire logic [34:0] o_init_vector,
    input wire logic o_ks_ready,
    input wire logic o_fld_ready,
    input wire logic o_fld_valid,
    input wire logic o_fld_bit,
    input wire logic o_enc_active
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    AST_ERR_PHASE: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("slave error outside access phase");
    AST_LOAD_PULSE: assert property (o_ksg_load |=> !o_ksg_load)
        else $error("load pulse longer than one cycle");
    AST_LOAD_CAUSE: assert property (o_ksg_load |-> $past(i_frame_strobe, 2))
        else $error("load without frame strobe two cycles before");
    AST_LOAD_MODE: assert property (o_ksg_load |-> o_enc_active)
        else $error("generator loaded in clear mode");
    AST_IV_BUILD: assert property (o_ksg_load |-> o_init_vector[34:32] == 3'h0 &&
        o_init_vector[27:0] == {$past(i_multiframe, 2), $past(i_frame_num, 2)})
        else $error("init vector not built from frame and multiframe");
    AST_KS_OPEN: assert property (o_ksg_load |-> ##[0:2] o_ks_ready)
        else $error("key collection not opened after load");
    AST_FLD_LAT: assert property (i_fld_valid && o_fld_ready |=> o_fld_valid)
        else $error("accepted field bit not output next cycle");
    AST_FLD_IDLE: assert property (!(i_fld_valid && o_fld_ready) |=> !o_fld_valid)
        else $error("field output without accepted bit");
    AST_CLEAR_PASS: assert property (i_fld_valid && o_fld_ready && !o_enc_active |=>
        o_fld_bit == $past(i_fld_bit))
        else $error("clear mode altered a field bit");
    AST_MODE_STROBE: assert property ($changed(o_enc_active) |-> $past(i_frame_strobe))
        else $error("mode changed away from a frame start");
endmodule // mke_checker
bind mke_keystream_cipher mke_checker u_chk (.i_sys_clk, .i_rst_b, .i_psel, .i_penable, .i_frame_strobe,
    .i_frame_num, .i_multiframe, .i_fld_valid, .i_fld_bit, .o_pslverr, .o_ksg_load, .o_init_vector,
    .o_ks_ready, .o_fld_ready, .o_fld_valid, .o_fld_bit, .o_enc_active);
`default_nettype wire

// *** tb/mke_ksg_model.sv ***
// Key stream generator model: 720 bits after each load, with regular stalls.
// Assumes the block's clock, its load pulse and its ready handshake.
`timescale 1ns/1ps
`default_nettype none
module mke_ksg_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic [34:0] i_init_vector,
    input wire logic i_ready,
    output logic o_valid,
    output logic o_bit
);
    logic [9:0] cnt;
    logic [9:0] nxt;
    logic [1:0] gap;
    logic [34:0] iv;
    function automatic logic ks(input logic [9:0] k, input logic [34:0] v);
        return ^(k & 10'h2A5) ^ (k[3] & v[0]) ^ v[1];
    endfunction
    assign nxt = o_valid ? cnt + 10'h001 : cnt;
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 10'h2D0;
            gap <= 2'h0;
            iv <= 35'h0;
            o_valid <= 1'b0;
            o_bit <= 1'b0;
        end else if (i_load) begin
            cnt <= 10'h000;
            iv <= i_init_vector;
            o_valid <= 1'b0;
        end else if (!o_valid || i_ready) begin
            gap <= gap + 2'h1;
            cnt <= nxt;
            if (nxt < 10'h2D0 && gap != 2'h3) begin
                o_valid <= 1'b1;
                o_bit <= ks(nxt, iv);
            end else begin
                // Idle line toggles so a stale bit is never mistaken for data
                o_valid <= 1'b0;
                o_bit <= ~o_bit;
            end
        end
    end
endmodule // mke_ksg_model
`default_nettype wire

// *** tb/tb_mke_keystream_cipher.sv ***
// Testbench: registers, clear and encrypted fields, segment choice, mode switch.
// Assumes the generator model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_mke_keystream_cipher;
    logic clk = 0, rst_b = 0, psel = 0, pen = 0, pw = 0, fs = 0, fv = 0, ff = 0, frx = 0, fsec = 0, fb = 0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prdata, rd;
    logic [3:0] fn = 4'h0;
    logic [23:0] mf = 24'hA5C3E1;
    logic [34:0] iv;
    logic [127:0] ck;
    logic pready, pslverr, load, ksv, ksb, ksr, ofr, ofv, ofb, enc, er, fixd, dsx, adv;
    int fail_count = 0, checks = 0, fmt = 0, npay = 160;
    always #25 clk = ~clk;
    mke_keystream_cipher u_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_frame_strobe(fs), .i_frame_num(fn), .i_multiframe(mf), .o_ksg_load(load), .o_init_vector(iv),
        .o_cipher_key(ck), .i_ks_valid(ksv), .i_ks_bit(ksb), .o_ks_ready(ksr), .i_fld_valid(fv),
        .i_fld_first(ff), .i_fld_rx(frx), .i_fld_second(fsec), .i_fld_bit(fb), .o_fld_ready(ofr),
        .o_fld_valid(ofv), .o_fld_bit(ofb), .o_enc_active(enc));
    mke_ksg_model u_ksg (.i_sys_clk(clk), .i_rst_b(rst_b), .i_load(load), .i_init_vector(iv),
        .i_ready(ksr), .o_valid(ksv), .o_bit(ksb));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic ks(input logic [9:0] k, input logic [3:0] f);
        return ^(k & 10'h2A5) ^ (k[3] & f[0]) ^ f[1];
    endfunction
    function automatic logic dat(input int p, input logic [7:0] h);
        return (p < 8) ? h[p] : ^(p[8:0] & 9'h0B3);
    endfunction
    function automatic logic expb(input int p, input logic [7:0] h, input logic sp, input logic on);
        int b;
        int k;
        b = p - 64;
        k = -1;
        if (p >= 8 && p < 48 && h[3:1] == 3'h6) k = p - 8;
        if (b >= 0 && b < 320 && (fmt == 0 || (fmt == 1 && b < 304) || (fmt == 2 && b % 80 < 64)
            || (fmt == 3 && b < npay))) k = b + 40;
        return dat(p, h) ^ (on && k >= 0 && ks(k + (sp ? 360 : 0), fn));
    endfunction
    task field(input logic rx, input logic sec, input logic [7:0] h, input logic on);
        logic sp;
        sp = dsx ? sec : (fixd ? rx : !rx);
        frx <= rx;
        fsec <= sec;
        for (int p = 0; p < 388; p++) begin
            fv <= 1'b1;
            ff <= (p == 0);
            fb <= dat(p, h);
            @(negedge clk);
            while (ofr !== 1'b1) @(negedge clk);
            @(posedge clk);
            fv <= 1'b0;
            @(negedge clk);
            chk({ofv, ofb}, {1'b1, expb(p, h, sp, on)});
            @(posedge clk);
        end
    endtask
    task frame(input logic [3:0] f);
        fs <= 1'b1;
        fn <= f;
        @(posedge clk);
        fs <= 1'b0;
        // Load follows the strobe by two edges
        repeat (3) @(posedge clk);
    endtask
    initial begin
        #4000000;
        fail_count++;
        conclude;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(0, 8'h00, 0);
        chk(rd, 0);
        apb(0, 8'h04, 0);
        chk(rd, 6);
        apb(0, 8'h0C, 0);
        chk(rd, 32'h140);
        apb(1, 8'h1C, 32'hFFFF);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1, 8'h20, 32'h89ABCDEF);
        apb(1, 8'h24, 32'h01234567);
        apb(1, 8'h28, 32'hFEDCBA98);
        apb(1, 8'h2C, 32'h76543210);
        chk(ck, 64'h0123456789ABCDEF);
        apb(1, 8'h00, 32'h40);
        chk(ck[127:64], 64'h76543210FEDCBA98);
        apb(1, 8'h00, 32'h0);
        frame(4'h3);
        chk(enc, 0);
        fixd = 1;
        dsx = 0;
        field(0, 0, 8'h0C, 0);
        apb(1, 8'h08, 5);
        apb(1, 8'h0C, npay);
        apb(1, 8'h10, {4'h0, mf, 4'h0});
        apb(1, 8'h14, {4'h0, mf, 4'hF});
        // Every format, both ends, both directions, control and other tails
        for (int i = 0; i < 4; i++) begin
            fmt = i;
            fixd = (i < 2);
            adv = i[0];
            apb(1, 8'h00, {26'h0, i[1:0], 1'b0, adv, fixd, 1'b1});
            frame(i[3:0]);
            chk(enc, 1);
            chk(iv, {3'h0, adv ? 4'hA : 4'h0, mf, i[3:0]});
            field(0, 0, i[0] ? 8'h02 : 8'h0C, 1);
            field(1, 0, 8'h0C, 1);
        end
        fmt = 2;
        dsx = 1;
        apb(1, 8'h00, 32'h2B);
        frame(4'h4);
        field(0, 0, 8'h0C, 1);
        field(0, 1, 8'h0C, 1);
        dsx = 0;
        frame(4'hF);
        chk(enc, 0);
        field(0, 0, 8'h0C, 0);
        apb(0, 8'h18, 0);
        chk(rd[0], 0);
        conclude;
    end
endmodule // tb_mke_keystream_cipher
`default_nettype wire
